/* core/fcdma_core.v */
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fcdma_map.vh"

// Function
// - four independent channels, each with own control, count and pointers
// - every transfer spends at least two clocks: read then write
// - channel holds 16-bit control, 16-bit count, three 24-bit pointers
// - source pointer stays, or steps up or down by transfer size
// - step codes: 00 fixed, 01 increment, 10 decrement, 11 reserved
// - count drops by exactly one per transfer, any width
// - count at zero closes buffer, then stop or load next descriptor
// - width code 00 byte, 01 word, 10 quad; steps 1, 2, 4
// - one buffer holds up to 64K transfers of selected width
// - descriptors are 16 bytes on a 16-byte boundary
// - descriptor: control 0, count 2, dest 4, source 8, next 0ch
// - enable by software starts direct; list write fetches, linked mode
// - loop bit in linked mode suppresses descriptor write-back
// - buffer-end irq enable raises interrupt at every buffer close
// - follow bit takes next pointer from descriptor, else adds 16
// - end-of-frame bit signals frame end on last transfer, count one
// - early peripheral frame-end request sets the end-of-frame bit
// - halt bit stops after close; list pointer advanced, no fetch
// - command bits go to peripheral on first transfer of buffer
// - with end-of-frame bit, close captures peripheral status
// - direct mode watermark from list bits 23:16 raises interrupt when buffer-end irq enable is set
// - acknowledge to peripheral while its request is serviced
// - command-valid with command bus on first write of buffer
// - frame-end request closes buffer, ack and status read, capture
// - buffer closure clears the channel enable bit
module fcdma_core (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // memory master
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg  [23:0] mem_adr_o,
  output reg  [1:0]  mem_size_o,
  output reg  [31:0] mem_dat_o,
  input  wire [31:0] mem_dat_i,
  input  wire        mem_ack_i,
  // peripheral side
  input  wire [3:0]  preq_i,
  input  wire [3:0]  peof_req_i,
  input  wire [3:0]  status_bus_i,
  output reg  [3:0]  pack_o,
  output reg         command_valid_o,
  output reg  [3:0]  command_bus_o,
  output reg         eof_sync_o,
  output reg         status_read_strobe_o,
  output reg  [3:0]  irq_o
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_RD    = 3'h1;
  localparam [2:0] S_WR    = 3'h2;
  localparam [2:0] S_FETCH = 3'h3;
  localparam [2:0] S_CLOSE = 3'h4;
  localparam [2:0] S_WB    = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel register state
  reg [15:0] ctl_r   [0:3];
  reg [15:0] count_r [0:3];
  reg [23:0] dst_r   [0:3];
  reg [23:0] src_r   [0:3];
  reg [23:0] list_r  [0:3];
  reg [23:0] desc_r  [0:3];   // base of descriptor in use
  reg [23:0] next_r  [0:3];   // next pointer read from descriptor
  reg [3:0]  lnk_r;           // channel loaded from a descriptor
  reg [3:0]  first_r;         // next transfer opens a new buffer
  reg [3:0]  fetch_r;         // descriptor fetch pending
  reg [2:0]  state_r;
  reg [1:0]  gnt_r;
  reg [1:0]  fidx_r;
  reg        early_r;         // closure caused by frame-end request
  reg [31:0] data_r;

  // pointer step by selected width and direction
  function [23:0] step;
    input [23:0] ptr;
    input [1:0]  mode;
    input [1:0]  wid;
    reg   [23:0] inc;
    begin
      inc = 24'h000001 << wid;
      if (mode == `FCDMA_STEP_INC)
        step = ptr + inc;
      else if (mode == `FCDMA_STEP_DEC)
        step = ptr - inc;
      else
        step = ptr;   // fixed, and reserved code held as fixed
    end
  endfunction

  // byte-lane merge of a bus write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request selection: lowest runnable channel wins
  reg [1:0] pick;
  reg       pick_v;
  reg       pick_eof;
  integer   j;
  always @* begin
    pick     = 2'h0;
    pick_v   = 1'b0;
    pick_eof = 1'b0;
    for (j = 3; j >= 0; j = j - 1) begin
      if (fetch_r[j] ||
          (ctl_r[j][`FCDMA_CTL_EN] && (preq_i[j] || peof_req_i[j]))) begin
        pick     = j[1:0];
        pick_v   = 1'b1;
        pick_eof = !fetch_r[j] && peof_req_i[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode helpers
  wire       wb_hit  = cyc_i && stb_i && !ack_o;
  wire [1:0] wb_ch   = adr_i[6:5];
  wire [2:0] wb_reg  = adr_i[4:2];
  wire       wb_chan = !adr_i[7];
  // lane-merged write values; each register keeps only its own low bits
  wire [31:0] ctl_wr  = merge({16'h0000, ctl_r[wb_ch]}, dat_i, sel_i);
  wire [31:0] cnt_wr  = merge({16'h0000, count_r[wb_ch]}, dat_i, sel_i);
  wire [31:0] dst_wr  = merge({8'h00, dst_r[wb_ch]}, dat_i, sel_i);
  wire [31:0] src_wr  = merge({8'h00, src_r[wb_ch]}, dat_i, sel_i);
  wire [31:0] list_wr = merge({8'h00, list_r[wb_ch]}, dat_i, sel_i);

  reg  [15:0] cur_ctl;
  reg  [15:0] cnt_dec;
  reg  [15:0] nctl;
  reg  [23:0] lar_nxt;
  always @* begin
    cur_ctl = ctl_r[gnt_r];
    cnt_dec = count_r[gnt_r] - 16'h0001;
    // follow pointer or step by 16
    lar_nxt = cur_ctl[`FCDMA_CTL_FOLLOW_NEXT_POINTER] ? next_r[gnt_r]
                                        : desc_r[gnt_r] + `FCDMA_DSC_SIZE;
    nctl = cur_ctl;
    nctl[`FCDMA_CTL_EN] = 1'b0;
    if (early_r)
      nctl[`FCDMA_CTL_EOF] = 1'b1;
    if (cur_ctl[`FCDMA_CTL_EOF] || early_r)
      nctl[`FCDMA_CTL_CMD_LO +: 4] = status_bus_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine and register file; bus writes land after engine updates
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctl_r[i]   <= `FCDMA_RST_CTL;
        count_r[i] <= `FCDMA_RST_COUNT;
        dst_r[i]   <= `FCDMA_RST_PTR;
        src_r[i]   <= `FCDMA_RST_PTR;
        list_r[i]  <= `FCDMA_RST_PTR;
        desc_r[i]  <= `FCDMA_RST_PTR;
        next_r[i]  <= `FCDMA_RST_PTR;
      end
      lnk_r   <= 4'h0;
      first_r <= 4'h0;
      fetch_r <= 4'h0;
      state_r <= S_IDLE;
      gnt_r   <= 2'h0;
      fidx_r  <= 2'h0;
      early_r <= 1'b0;
      data_r  <= 32'h00000000;
      dat_o   <= 32'h00000000;
      ack_o   <= 1'b0;
      mem_req_o  <= 1'b0;
      mem_we_o   <= 1'b0;
      mem_adr_o  <= 24'h000000;
      mem_size_o <= 2'h0;
      mem_dat_o  <= 32'h00000000;
      pack_o          <= 4'h0;
      command_valid_o <= 1'b0;
      command_bus_o   <= 4'h0;
      eof_sync_o      <= 1'b0;
      status_read_strobe_o <= 1'b0;
      irq_o <= 4'h0;
    end else begin
      // one-cycle pulses
      status_read_strobe_o <= 1'b0;
      irq_o <= 4'h0;
      case (state_r)
        S_IDLE: begin
          pack_o <= 4'h0;
          if (pick_v) begin
            gnt_r <= pick;
            if (fetch_r[pick]) begin
              desc_r[pick]  <= {list_r[pick][23:4], 4'h0};
              fetch_r[pick] <= 1'b0;
              fidx_r     <= 2'h0;
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b0;
              mem_size_o <= `FCDMA_WID_QUAD;
              mem_adr_o  <= {list_r[pick][23:4], 4'h0};
              state_r    <= S_FETCH;
            end else if (pick_eof) begin
              early_r <= (count_r[pick] != 16'h0000);
              pack_o[pick] <= 1'b1;
              state_r <= S_CLOSE;
            end else begin
              pack_o[pick] <= 1'b1;
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b0;
              mem_size_o <= ctl_r[pick][`FCDMA_CTL_WID_LO +: 2];
              mem_adr_o  <= src_r[pick];
              early_r    <= 1'b0;
              state_r    <= S_RD;
            end
          end
        end
        S_RD: begin
          if (mem_ack_i) begin
            data_r    <= mem_dat_i;
            mem_dat_o <= mem_dat_i;
            mem_we_o  <= 1'b1;
            mem_adr_o <= dst_r[gnt_r];
            command_valid_o <= first_r[gnt_r];
            command_bus_o   <= cur_ctl[`FCDMA_CTL_CMD_LO +: 4];
            eof_sync_o <= cur_ctl[`FCDMA_CTL_EOF] &&
                          (count_r[gnt_r] == 16'h0001);
            state_r <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack_i) begin
            mem_req_o       <= 1'b0;
            mem_we_o        <= 1'b0;
            command_valid_o <= 1'b0;
            eof_sync_o      <= 1'b0;
            first_r[gnt_r]  <= 1'b0;
            src_r[gnt_r] <= step(src_r[gnt_r],
                                 cur_ctl[`FCDMA_CTL_SRC_LO +: 2],
                                 cur_ctl[`FCDMA_CTL_WID_LO +: 2]);
            dst_r[gnt_r] <= step(dst_r[gnt_r],
                                 cur_ctl[`FCDMA_CTL_DST_LO +: 2],
                                 cur_ctl[`FCDMA_CTL_WID_LO +: 2]);
            count_r[gnt_r] <= cnt_dec;
            if (!lnk_r[gnt_r] && cur_ctl[`FCDMA_CTL_BUFFER_END_IRQ_ENABLE] &&
                list_r[gnt_r][23:16] != 8'h00 && cnt_dec[15:8] == 8'h00 &&
                cnt_dec[7:0] == list_r[gnt_r][23:16])
              irq_o[gnt_r] <= 1'b1;
            if (cnt_dec == 16'h0000) begin
              state_r <= S_CLOSE;
            end else begin
              pack_o  <= 4'h0;
              state_r <= S_IDLE;
            end
          end
        end
        S_CLOSE: begin
          ctl_r[gnt_r] <= nctl;
          status_read_strobe_o <= cur_ctl[`FCDMA_CTL_EOF] || early_r;
          irq_o[gnt_r] <= cur_ctl[`FCDMA_CTL_BUFFER_END_IRQ_ENABLE] || early_r;
          if (lnk_r[gnt_r] && !cur_ctl[`FCDMA_CTL_LOOP]) begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b1;
            mem_size_o <= `FCDMA_WID_WORD;
            mem_adr_o  <= desc_r[gnt_r];
            mem_dat_o  <= {16'h0000, nctl};
            state_r    <= S_WB;
          end else begin
            if (lnk_r[gnt_r]) begin
              list_r[gnt_r]  <= lar_nxt;
              fetch_r[gnt_r] <= !cur_ctl[`FCDMA_CTL_HALT];
            end
            // acknowledge stands beside the status strobe; idle drops it
            state_r <= S_IDLE;
          end
        end
        S_WB: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
            list_r[gnt_r]  <= lar_nxt;
            fetch_r[gnt_r] <= !cur_ctl[`FCDMA_CTL_HALT];
            pack_o  <= 4'h0;
            state_r <= S_IDLE;
          end
        end
        S_FETCH: begin
          if (mem_ack_i) begin
            fidx_r <= fidx_r + 2'h1;
            if (fidx_r == 2'h0) begin
              ctl_r[gnt_r]   <= mem_dat_i[15:0];
              count_r[gnt_r] <= mem_dat_i[31:16];
              mem_adr_o <= desc_r[gnt_r] + `FCDMA_DSC_DST;
            end else if (fidx_r == 2'h1) begin
              dst_r[gnt_r] <= mem_dat_i[23:0];
              mem_adr_o <= desc_r[gnt_r] + `FCDMA_DSC_SRC;
            end else if (fidx_r == 2'h2) begin
              src_r[gnt_r] <= mem_dat_i[23:0];
              mem_adr_o <= desc_r[gnt_r] + `FCDMA_DSC_NEXT;
            end else begin
              next_r[gnt_r] <= mem_dat_i[23:0];
              lnk_r[gnt_r]   <= 1'b1;
              first_r[gnt_r] <= 1'b1;
              mem_req_o <= 1'b0;
              state_r   <= S_IDLE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase

      // wishbone slave: one-wait answer, unmapped reads as zero
      ack_o <= wb_hit;
      if (wb_hit) begin
        dat_o <= 32'h00000000;
        if (!wb_chan) begin
          if (adr_i == `FCDMA_ADR_STATUS)
            dat_o <= {21'h000000, state_r, fetch_r, lnk_r};
        end else if (wb_reg == `FCDMA_OFS_CTL) begin
          dat_o <= {16'h0000, ctl_r[wb_ch]};
          if (we_i) begin
            ctl_r[wb_ch]   <= ctl_wr[15:0];
            lnk_r[wb_ch]   <= 1'b0;
            first_r[wb_ch] <= 1'b1;
          end
        end else if (wb_reg == `FCDMA_OFS_COUNT) begin
          dat_o <= {16'h0000, count_r[wb_ch]};
          if (we_i)
            count_r[wb_ch] <= cnt_wr[15:0];
        end else if (wb_reg == `FCDMA_OFS_DST) begin
          dat_o <= {8'h00, dst_r[wb_ch]};
          if (we_i)
            dst_r[wb_ch] <= dst_wr[23:0];
        end else if (wb_reg == `FCDMA_OFS_SRC) begin
          dat_o <= {8'h00, src_r[wb_ch]};
          if (we_i)
            src_r[wb_ch] <= src_wr[23:0];
        end else if (wb_reg == `FCDMA_OFS_LIST) begin
          dat_o <= {8'h00, list_r[wb_ch]};
          if (we_i) begin
            list_r[wb_ch] <= list_wr[23:0];
            // low-lane write of a nonzero pointer starts a fetch;
            // watermark-only writes via lane 2 leave the channel alone
            if (sel_i[0] && dat_i[15:0] != 16'h0000)
              fetch_r[wb_ch] <= 1'b1;
          end
        end
      end
    end
  end

endmodule // fcdma_core
`default_nettype wire

/* core/fcdma_map.vh */
`ifndef FCDMA_MAP_VH
`define FCDMA_MAP_VH
// register word indices inside a channel window (window = 32 bytes)
`define FCDMA_OFS_CTL      3'h0
`define FCDMA_OFS_COUNT    3'h1
`define FCDMA_OFS_DST      3'h2
`define FCDMA_OFS_SRC      3'h3
`define FCDMA_OFS_LIST     3'h4
// global status word sits above the four channel windows
`define FCDMA_ADR_STATUS   8'h80
// control word fields
`define FCDMA_CTL_EN       0
`define FCDMA_CTL_LOOP     1
`define FCDMA_CTL_WID_LO   2
`define FCDMA_CTL_DST_LO   4
`define FCDMA_CTL_SRC_LO   6
`define FCDMA_CTL_BUFFER_END_IRQ_ENABLE     8
`define FCDMA_CTL_FOLLOW_NEXT_POINTER     9
`define FCDMA_CTL_EOF      10
`define FCDMA_CTL_HALT     11
`define FCDMA_CTL_CMD_LO   12
// step and width codes
`define FCDMA_STEP_FIXED   2'h0
`define FCDMA_STEP_INC     2'h1
`define FCDMA_STEP_DEC     2'h2
`define FCDMA_WID_BYTE     2'h0
`define FCDMA_WID_WORD     2'h1
`define FCDMA_WID_QUAD     2'h2
// descriptor layout (byte offsets from its base)
`define FCDMA_DSC_CTLCNT   24'h000000
`define FCDMA_DSC_DST      24'h000004
`define FCDMA_DSC_SRC      24'h000008
`define FCDMA_DSC_NEXT     24'h00000c
`define FCDMA_DSC_SIZE     24'h000010
// reset values
`define FCDMA_RST_CTL      16'h0000
`define FCDMA_RST_COUNT    16'h0000
`define FCDMA_RST_PTR      24'h000000
`endif

/* test/fcdma_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fcdma_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [23:0] mem_adr_o,
  input wire logic        mem_ack_i,
  input wire logic [3:0]  pack_o,
  input wire logic        command_valid_o,
  input wire logic [3:0]  command_bus_o,
  input wire logic        eof_sync_o,
  input wire logic        status_read_strobe_o,
  input wire logic [3:0]  irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_wb_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("register access not answered");
  a_req_holds: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_adr_o) && $stable(mem_we_o))
    else $error("memory request changed before ack");
  a_read_first: assert property ($rose(command_valid_o) |->
    $past(mem_ack_i) && !$past(mem_we_o))
    else $error("write not preceded by a read");
  a_cmd_write: assert property (command_valid_o |->
    mem_req_o && mem_we_o && pack_o != 4'h0)
    else $error("command valid outside a serviced write");
  a_cmd_stands: assert property (command_valid_o && !mem_ack_i |=>
    command_valid_o && $stable(command_bus_o))
    else $error("command dropped before write ack");
  a_eof_write: assert property (eof_sync_o |->
    mem_we_o && $onehot(pack_o))
    else $error("frame end outside a write");
  a_status_ack: assert property (status_read_strobe_o |->
    pack_o != 4'h0 ##1 !status_read_strobe_o)
    else $error("status strobe without ack or too long");
  a_one_grant: assert property ($onehot0(pack_o))
    else $error("more than one channel granted");
  a_irq_pulse: assert property (irq_o != 4'h0 |=>
    (irq_o & $past(irq_o)) == 4'h0)
    else $error("interrupt longer than one cycle");
endmodule // fcdma_props
bind fcdma_core fcdma_props u_props (.*);
`default_nettype wire

/* test/fcdma_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcdma_mem_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [23:0] adr_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  output var  logic        ack_o
);
  logic [31:0] mem [0:63];
  logic [1:0]  wait_r;
  initial begin
    ack_o = 1'b0;
    dat_o = 32'h0;
    wait_r = 2'h0;
    for (int i = 0; i < 64; i++) mem[i] = 32'h0;
  end
  ////////////////////////////////////////
  // one access per ack, word index
  // read data toggles when idle so stale data never looks valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    dat_o <= ~dat_o;
    if (req_i && !ack_o) begin
      if (!slow_i || wait_r == 2'h3) begin
        ack_o <= 1'b1;
        wait_r <= 2'h0;
        if (we_i) mem[adr_i[7:2]] <= dat_i;
        else dat_o <= mem[adr_i[7:2]];
      end else wait_r <= wait_r + 2'h1;
    end
  end
endmodule // fcdma_mem_model
`default_nettype wire

/* test/test_four_channel_dma_core.sv */
`timescale 1ns/1ps
`default_nettype none
module test_four_channel_dma_core;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h0;
  logic [3:0]  sel_i = 4'h0, preq_i = 4'h0, peof_req_i = 4'h0;
  logic [3:0]  status_bus_i = 4'h9, pack_o, command_bus_o, irq_o, lcmd;
  logic [31:0] dat_i = 32'h0, dat_o, mem_dat_o, mem_dat_i, rd;
  logic [23:0] mem_adr_o;
  logic [1:0]  mem_size_o;
  logic ack_o, mem_req_o, mem_we_o, mem_ack_i, command_valid_o, slow_i = 1'b0;
  logic eof_sync_o, status_read_strobe_o;
  logic cv_q = 1'b0, eof_q = 1'b0;
  logic [1:0]  lsize;
  int fail_count = 0, compares = 0, ncmd, neof, nirq, nstr;
  fcdma_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_adr_o(mem_adr_o), .mem_size_o(mem_size_o), .mem_dat_o(mem_dat_o),
    .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .preq_i(preq_i),
    .peof_req_i(peof_req_i), .status_bus_i(status_bus_i), .pack_o(pack_o),
    .command_valid_o(command_valid_o), .command_bus_o(command_bus_o),
    .eof_sync_o(eof_sync_o), .status_read_strobe_o(status_read_strobe_o),
    .irq_o(irq_o));
  fcdma_mem_model mm (.clk_i(clk_i), .slow_i(slow_i), .req_i(mem_req_o),
    .we_i(mem_we_o), .adr_i(mem_adr_o), .dat_i(mem_dat_o), .dat_o(mem_dat_i),
    .ack_o(mem_ack_i));
  initial forever #10 clk_i = ~clk_i;
  ////////////////////////////////////////
  // count strobes at mid-cycle, away from the tasks' zeroing edge;
  // command and frame-end stand until the write ack, so count rises
  always @(negedge clk_i) begin
    cv_q  <= command_valid_o;
    eof_q <= eof_sync_o;
    if (command_valid_o === 1'b1 && cv_q !== 1'b1) ncmd <= ncmd + 1;
    if (command_valid_o === 1'b1) lcmd <= command_bus_o;
    if (eof_sync_o === 1'b1 && eof_q !== 1'b1) neof <= neof + 1;
    if (status_read_strobe_o === 1'b1) nstr <= nstr + 1;
    if (mem_req_o === 1'b1 && mem_we_o === 1'b0) lsize <= mem_size_o;
    nirq <= nirq + $countones(irq_o);
  end
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      test_done();
    end
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e,
                      input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    check(nm, rd & m, e);
  endtask
  // engine progress is seen only through registers, so poll them
  task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
    for (int k = 0; k < 60; k++) begin
      wb(1'b0, a, 32'h0, 4'hf);
      if ((rd & m) === v) return;
    end
    fail_count++;
    test_done();
  endtask
  task automatic t_regs;
    rchk(8'h80, 32'hffffffff, 32'h0, "status");
    for (int a = 8'h64; a <= 8'h6c; a += 4) begin
      rchk(8'(a), 32'hffffffff, 32'h0, "reset");
      wb(1'b1, 8'(a), 32'hffffffff, 4'hf);
      rchk(8'(a), 32'hffffffff, a == 8'h64 ? 32'hffff : 32'hffffff,
           "w");
      wb(1'b1, 8'(a), 32'h0, 4'hf);
    end
    wb(1'b1, 8'hfc, 32'hffffffff, 4'hf);
    rchk(8'hfc, 32'hffffffff, 32'h0, "unmapped");
  endtask
  // each width with its own source step, two transfers, watermark one
  task automatic t_direct;
    logic [15:0] c;
    logic [31:0] sz;
    for (int w = 0; w < 3; w++) begin
      sz = 32'h1 << w;
      c = 16'h5511 | 16'(w << 6) | 16'(w << 2);
      wb(1'b1, 8'h08, 32'h60, 4'hf);
      wb(1'b1, 8'h0c, 32'h40, 4'hf);
      wb(1'b1, 8'h04, 32'h2, 4'hf);
      wb(1'b1, 8'h10, 32'h00010000, 4'h4);
      {ncmd, neof, nirq, nstr} = '0;
      wb(1'b1, 8'h00, {16'h0, c}, 4'hf);
      preq_i <= 4'h1;
      poll(8'h00, 32'h1, 32'h0);
      preq_i <= 4'h0;
      rchk(8'h04, 32'hffffffff, 32'h0, "count");
      rchk(8'h0c, 32'hffffff, w == 1 ? 32'h40 + 2 * sz :
           w == 2 ? 32'h40 - 2 * sz : 32'h40, "src");
      rchk(8'h08, 32'hffffff, 32'h60 + 2 * sz, "dst");
      rchk(8'h00, 32'hffff, (c & 16'h0ffe) | 16'h9000, "ctl");
      check("cmd", ncmd, 32'h1);
      check("command_bus", lcmd, 32'h5);
      check("eof", neof, 32'h1);
      check("irq", nirq, 32'h2);
      check("size", lsize, w);
      check("strobe", nstr, 32'h1);
    end
  endtask
  task automatic t_early;
    status_bus_i <= 4'h6;
    wb(1'b1, 8'h24, 32'h5, 4'hf);
    {nirq, nstr} = '0;
    wb(1'b1, 8'h20, 32'h1, 4'hf);
    peof_req_i <= 4'h2;
    poll(8'h20, 32'h1, 32'h0);
    peof_req_i <= 4'h0;
    rchk(8'h20, 32'hf401, 32'h6400, "ctl");
    rchk(8'h24, 32'hffff, 32'h5, "count");
    check("irq", nirq, 32'h1);
    check("strobe", nstr, 32'h1);
  endtask
  // one quad descriptor, follow and halt set, slow memory
  task automatic t_list;
    mm.mem[16] = 32'h00013a59;
    mm.mem[17] = 32'hc0;
    mm.mem[18] = 32'he0;
    mm.mem[19] = 32'h80;
    mm.mem[56] = 32'h12345678;
    slow_i <= 1'b1;
    wb(1'b1, 8'h50, 32'h40, 4'hf);
    poll(8'h4c, 32'hffffff, 32'he0);
    rchk(8'h40, 32'hffff, 32'h3a59, "ctl");
    rchk(8'h44, 32'hffff, 32'h1, "count");
    rchk(8'h48, 32'hffffff, 32'hc0, "dst");
    rchk(8'h80, 32'h4, 32'h4, "linked");
    preq_i <= 4'h4;
    poll(8'h40, 32'h1, 32'h0);
    preq_i <= 4'h0;
    poll(8'h80, 32'h7f0, 32'h0);
    rchk(8'h50, 32'hffffff, 32'h80, "list");
    check("data", mm.mem[48], 32'h12345678);
    check("wback", {16'h0, mm.mem[16][15:0]}, 32'h3a58);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_direct();
    t_early();
    t_list();
    test_done();
  end
endmodule // test_four_channel_dma_core
`default_nettype wire
